// *** cmp_gate_pkg.sv ***
package cmp_gate_pkg;
    // apb byte addresses of the two control registers
    localparam logic [3:0] gate_ctrl_addr   = 4'h0;
    localparam logic [3:0] ref_ctrl_addr    = 4'h4;
    // gate/sync control fields
    localparam int         gate_sel_bit     = 1;
    localparam int         sync_bit         = 0;
    localparam logic [7:0] gate_ctrl_mask   = 8'h03;
    localparam logic [7:0] gate_ctrl_rst    = 8'h02;
    // reference ladder control fields
    localparam int         ref_en_bit       = 7;
    localparam int         ref_range_bit    = 5;
    localparam int         ref_level_lsb    = 0;
    localparam int         ref_level_w      = 4;
    localparam logic [7:0] ref_ctrl_mask    = 8'hAF;
    localparam logic [7:0] ref_ctrl_rst     = 8'h00;
    // ladder tap numbering: low range code of 24 steps, high range 8 of 32 plus code
    localparam logic [5:0] high_range_base  = 6'h08;
    localparam logic [5:0] low_range_scale  = 6'h18;
    localparam logic [5:0] high_range_scale = 6'h20;
endpackage : cmp_gate_pkg

// *** cmp_sync_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
// falling-edge capture of the comparator, clocked by the prescaled timer clock
module cmp_sync_latch
    import cmp_gate_pkg::*;
(
    // timer side
    input  wire logic tmr_clk,
    input  wire logic nrst,
    // data
    input  wire logic cmp_in,
    output var  logic cmp_held
);
    always_ff @(negedge tmr_clk) begin
        if (!nrst) begin
            cmp_held <= 1'b0;
        end else begin
            cmp_held <= cmp_in;
        end
    end
endmodule : cmp_sync_latch
`default_nettype wire

// *** cmp_gate_sync_vref_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module cmp_gate_sync_vref_ctrl
    import cmp_gate_pkg::*;
#(
    parameter int level_w = ref_level_w
)(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [3:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // comparator and timer
    input  wire logic               cmp_out,
    input  wire logic               external_gate_pin,
    input  wire logic               tmr_prescaled_clk,
    input  wire logic               tmr_on,
    input  wire logic               tmr_gate_en,
    output logic                    tmr_gate,
    output logic                    tmr_gate_active,
    // reference ladder
    output logic                    ref_enable,
    output logic                    ref_range_select,
    output logic [level_w-1:0]      ref_level_code,
    output logic [5:0]              ref_tap_num,
    output logic [5:0]              ref_tap_den
);
    typedef struct packed {
        logic [7:0]  gate_ctrl;
        logic [7:0]  ref_ctrl;
        logic [31:0] rdata;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic   cmp_held;
    logic   gate_source_select;
    logic   cmp_output_sync;
    logic   cmp_to_gate;
    logic   wr_en;
    logic   rd_en;
    logic   addr_ok;

    assign addr_ok = (paddr == gate_ctrl_addr) || (paddr == ref_ctrl_addr);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = st_reg.rdata;

    always_comb begin
        st_next = st_reg;
        if (wr_en && paddr == gate_ctrl_addr) begin
            st_next.gate_ctrl = pwdata[7:0] & gate_ctrl_mask;
        end
        if (wr_en && paddr == ref_ctrl_addr) begin
            st_next.ref_ctrl = pwdata[7:0] & ref_ctrl_mask;
        end
        if (rd_en) begin
            case (paddr)
                gate_ctrl_addr: st_next.rdata = {24'h000000, st_reg.gate_ctrl};
                ref_ctrl_addr:  st_next.rdata = {24'h000000, st_reg.ref_ctrl};
                default:        st_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg.gate_ctrl <= gate_ctrl_rst;
            st_reg.ref_ctrl  <= ref_ctrl_rst;
            st_reg.rdata     <= 32'h00000000;
        end else begin
            st_reg <= st_next;
        end
    end

    assign gate_source_select = st_reg.gate_ctrl[gate_sel_bit];
    assign cmp_output_sync    = st_reg.gate_ctrl[sync_bit];

    cmp_sync_latch u_sync (
        .tmr_clk  (tmr_prescaled_clk),
        .nrst     (nrst),
        .cmp_in   (cmp_out),
        .cmp_held (cmp_held)
    );

    assign cmp_to_gate = cmp_output_sync ? cmp_held : cmp_out;
    // gate source mux; cmp_out is the second comparator
    assign tmr_gate = gate_source_select ? external_gate_pin : cmp_to_gate;
    // gating only with timer on and gate enabled
    assign tmr_gate_active = tmr_on && tmr_gate_en && tmr_gate;
    // timer counts on rising edge outside; capture stays on falling edge

    // ladder power; no comparator mode input here
    assign ref_enable       = st_reg.ref_ctrl[ref_en_bit];
    assign ref_range_select = st_reg.ref_ctrl[ref_range_bit];
    assign ref_level_code   = st_reg.ref_ctrl[ref_level_lsb +: level_w];
    // tap ratio; disabled gives ground tap zero
    always_comb begin
        if (!ref_enable) begin
            ref_tap_num = 6'h00;
            ref_tap_den = low_range_scale;
        end else if (ref_range_select) begin
            ref_tap_num = 6'(ref_level_code);
            ref_tap_den = low_range_scale;
        end else begin
            ref_tap_num = high_range_base + 6'(ref_level_code);
            ref_tap_den = high_range_scale;
        end
    end

    // gate register reads zero in upper bits
    gate_upper_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.gate_ctrl & ~gate_ctrl_mask) == 8'h00)
        else $error("gate control upper bits set");
    ref_unused_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.ref_ctrl & ~ref_ctrl_mask) == 8'h00)
        else $error("reference unused bits set");
    gate_ext_route_a: assert property (@(posedge clk) disable iff (!nrst)
        gate_source_select |-> tmr_gate == external_gate_pin)
        else $error("external gate not routed");
    cmp_pass_a: assert property (@(posedge clk) disable iff (!nrst)
        (!gate_source_select && !cmp_output_sync) |-> tmr_gate == cmp_out)
        else $error("comparator not passed through");
    gate_off_a: assert property (@(posedge clk) disable iff (!nrst)
        (!tmr_on || !tmr_gate_en) |-> !tmr_gate_active)
        else $error("gate active with timer off");
    ref_ground_a: assert property (@(posedge clk) disable iff (!nrst)
        !ref_enable |-> ref_tap_num == 6'h00)
        else $error("reference not grounded");
    ref_high_tap_a: assert property (@(posedge clk) disable iff (!nrst)
        (ref_enable && !ref_range_select) |->
        (ref_tap_num == 6'(ref_level_code) + high_range_base && ref_tap_den == high_range_scale))
        else $error("high range tap wrong");
    gate_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && paddr == gate_ctrl_addr) |=>
        st_reg.gate_ctrl == ($past(pwdata[7:0]) & gate_ctrl_mask))
        else $error("gate control write lost");

    // synced comparator comes from held bit
    gate_sync_route_a: assert property (@(posedge clk) disable iff (!nrst)
        (!gate_source_select && cmp_output_sync) |-> tmr_gate == cmp_held)
        else $error("held comparator not routed");

    // comparator path when select bit clear
    gate_cmp_route_a: assert property (@(posedge clk) disable iff (!nrst)
        !gate_source_select |-> tmr_gate == cmp_to_gate)
        else $error("comparator path not routed");

    // gate passes with timer on and enabled
    gate_active_on_a: assert property (@(posedge clk) disable iff (!nrst)
        (tmr_on && tmr_gate_en) |-> tmr_gate_active == tmr_gate)
        else $error("gate not passed to timer");

    gate_active_src_a: assert property (@(posedge clk) disable iff (!nrst)
        tmr_gate_active |-> (tmr_on && tmr_gate_en && tmr_gate))
        else $error("gate active without cause");

    ref_low_tap_a: assert property (@(posedge clk) disable iff (!nrst)
        (ref_enable && ref_range_select) |->
        (ref_tap_num == 6'(ref_level_code) && ref_tap_den == low_range_scale))
        else $error("low range tap wrong");

    ref_clamp_a: assert property (@(posedge clk) disable iff (!nrst)
        (!ref_enable && ref_range_select && ref_level_code == '0) |-> ref_tap_num == 6'h00)
        else $error("clamped reference not at ground");

    // denominator is one of two scales
    ref_den_a: assert property (@(posedge clk) disable iff (!nrst)
        ref_tap_den == low_range_scale || ref_tap_den == high_range_scale)
        else $error("reference scale wrong");

    ref_tap_max_a: assert property (@(posedge clk) disable iff (!nrst)
        ref_tap_num < high_range_scale)
        else $error("reference tap too high");

    ref_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && paddr == ref_ctrl_addr) |=>
        st_reg.ref_ctrl == ($past(pwdata[7:0]) & ref_ctrl_mask))
        else $error("reference control write lost");

    gate_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !(wr_en && paddr == gate_ctrl_addr) |=> $stable(st_reg.gate_ctrl))
        else $error("gate control changed unwritten");

    // reference bits change only by write
    ref_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !(wr_en && paddr == ref_ctrl_addr) |=> $stable(st_reg.ref_ctrl))
        else $error("reference control changed unwritten");

    rdata_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_en && paddr == gate_ctrl_addr) |=> prdata == {24'h000000, $past(st_reg.gate_ctrl)})
        else $error("gate control read wrong");

    rdata_ref_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_en && paddr == ref_ctrl_addr) |=> prdata == {24'h000000, $past(st_reg.ref_ctrl)})
        else $error("reference control read wrong");

    rdata_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_en && !addr_ok) |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    // read data stands until next read
    rdata_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !rd_en |=> $stable(prdata))
        else $error("read data changed");

    rdata_upper_a: assert property (@(posedge clk) disable iff (!nrst)
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");

    slverr_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
        (psel && penable && !addr_ok) |-> pslverr)
        else $error("unmapped access not flagged");

    slverr_mapped_a: assert property (@(posedge clk) disable iff (!nrst)
        addr_ok |-> !pslverr)
        else $error("mapped access flagged");

    apb_ready_a: assert property (@(posedge clk) disable iff (!nrst)
        (psel && penable) |-> pready)
        else $error("access phase not ready");

    gate_reset_val_a: assert property (@(posedge clk)
        $rose(nrst) |-> st_reg.gate_ctrl == gate_ctrl_rst)
        else $error("gate control reset value wrong");

    ref_reset_val_a: assert property (@(posedge clk)
        $rose(nrst) |-> st_reg.ref_ctrl == ref_ctrl_rst)
        else $error("reference control reset value wrong");

    // held bit is last falling-edge sample
    sync_capture_a: assert property (@(negedge tmr_prescaled_clk) disable iff (!nrst)
        1'b1 |=> cmp_held == $past(cmp_out))
        else $error("held comparator not captured");

    sync_reset_a: assert property (@(negedge tmr_prescaled_clk)
        !nrst |=> !cmp_held)
        else $error("held comparator not cleared");

    ref_en_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && paddr == ref_ctrl_addr) |=> ref_enable == $past(pwdata[ref_en_bit]))
        else $error("reference enable not written");

    ref_range_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && paddr == ref_ctrl_addr) |=> ref_range_select == $past(pwdata[ref_range_bit]))
        else $error("reference range not written");

    gate_sel_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && paddr == gate_ctrl_addr) |=> gate_source_select == $past(pwdata[gate_sel_bit]))
        else $error("gate select not written");

    sync_bit_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_en && paddr == gate_ctrl_addr) |=> cmp_output_sync == $past(pwdata[sync_bit]))
        else $error("sync bit not written");
endmodule : cmp_gate_sync_vref_ctrl
`default_nettype wire

// *** gated_timer_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// timer behind a divide-by-four prescaler; its clock runs free, as a crystal would
module gated_timer_model (
    // system side
    input  wire logic        clk,
    input  wire logic        nrst,
    // timer side
    input  wire logic        gate_active,
    output var  logic        tmr_clk,
    output var  logic [15:0] count
);
    logic [1:0] div = 2'h0;
    always_ff @(posedge clk) div <= div + 2'h1;
    assign tmr_clk = div[1];
    always_ff @(posedge tmr_clk) count <= !nrst ? 16'h0000 : count + 16'(gate_active);
endmodule : gated_timer_model
`default_nettype wire

// *** tb_cmp_gate_sync_vref_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_cmp_gate_sync_vref_ctrl;
    import cmp_gate_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, err, cmp_out, external_gate_pin;
    logic tmr_on, tmr_gate_en, tmr_gate, tmr_gate_active, ref_enable, ref_range_select, tclk;
    logic [3:0]  paddr, ref_level_code;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  ref_tap_num, ref_tap_den;
    logic [15:0] cnt, c0;
    int failures = 0, tests_run = 0, cyc = 0;
    // rows: address, write data, read back, tap numerator, tap denominator, slave error
    logic [32:0] rows [7] = '{{4'h4, 8'hFF, 8'hAF, 6'h0F, 6'h18, 1'b0},
        {4'h4, 8'h8F, 8'h8F, 6'h17, 6'h20, 1'b0}, {4'h4, 8'h80, 8'h80, 6'h08, 6'h20, 1'b0},
        {4'h4, 8'h20, 8'h20, 6'h00, 6'h18, 1'b0}, {4'h0, 8'hFF, 8'h03, 6'h00, 6'h18, 1'b0},
        {4'h0, 8'h00, 8'h00, 6'h00, 6'h18, 1'b0}, {4'h8, 8'hFF, 8'h00, 6'h00, 6'h18, 1'b1}};
    cmp_gate_sync_vref_ctrl cmp_gate_sync_vref_ctrl_i (.clk, .nrst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_out, .external_gate_pin,
        .tmr_prescaled_clk(tclk), .tmr_on, .tmr_gate_en, .tmr_gate, .tmr_gate_active,
        .ref_enable, .ref_range_select, .ref_level_code, .ref_tap_num, .ref_tap_den);
    gated_timer_model gated_timer_model_i (.clk, .nrst, .gate_active(tmr_gate_active),
        .tmr_clk(tclk), .count(cnt));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        {nrst, psel, penable, pwrite, cmp_out, external_gate_pin, tmr_on, tmr_gate_en} = 8'h00;
        paddr = 4'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h02);
        apb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h00);
        $display("reset values done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i][32:29], {24'h0, rows[i][28:21]});
            apb(1'b0, rows[i][32:29], 32'h0);
            chk(rd, {24'h0, rows[i][20:13]});
            chk({ref_tap_num, ref_tap_den}, rows[i][12:1]);
            chk(err, rows[i][0]);
        end
        $display("register table done");
        @(posedge clk) cmp_out <= 1'b1;
        @(posedge clk) #1 chk(tmr_gate, 1'b1);
        apb(1'b1, 4'h0, 32'h1);
        @(negedge tclk);
        @(posedge clk) cmp_out <= 1'b0;
        @(posedge clk) #1 chk(tmr_gate, 1'b1);
        @(negedge tclk) #1 chk(tmr_gate, 1'b0);
        $display("sync capture done");
        apb(1'b1, 4'h0, 32'h2);
        @(posedge clk) external_gate_pin <= 1'b1;
        tmr_on <= 1'b1;
        @(posedge clk) #1 c0 = cnt;
        repeat (16) @(posedge clk);
        #1 chk(cnt, c0);
        chk(tmr_gate, 1'b1);
        @(posedge clk) tmr_gate_en <= 1'b1;
        @(posedge clk) #1 c0 = cnt;
        repeat (16) @(posedge clk);
        #1 chk(cnt, c0 + 16'h4);
        $display("gated counting done");
        apb(1'b1, 4'h4, 32'hA5);
        apb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'hA5);
        chk({ref_enable, ref_range_select, ref_level_code}, 32'h35);
        $display("reference fields done");
        @(posedge clk) nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h02);
        apb(1'b0, 4'h4, 32'h0);
        chk(rd, 32'h00);
        $display("mid-run reset done");
        finish_test();
    end
endmodule : tb_cmp_gate_sync_vref_ctrl
`default_nettype wire
